// ### common/ext_alu_regs.svh
// register offsets, field positions and reset values of the alu unit
// assumes a 32-bit apb bus with byte addresses on paddr
`ifndef EXT_ALU_REGS_SVH
`define EXT_ALU_REGS_SVH
`define ACC_OFS       8'h00
`define STATUS_OFS    8'h04
`define TPL_OFS       8'h08
`define TPH_OFS       8'h0C
`define TABLE_READ_HIGH_LATCH_OFS      8'h10
`define SECT_OFS      8'h14
`define CMD_OFS       8'h18
`define MADDR_OFS     8'h1C
`define MDATA_OFS     8'h20
`define FLG_CARRY     0
`define FLG_HALF      1
`define FLG_ZERO      2
`define FLG_EXCESS    3
`define FLG_SIGNED    4
`define STAT_BUSY     8
`define CMD_OP_LSB    0
`define CMD_DST_BIT   5
`define CMD_BIT_LSB   6
`define CMD_ADR_LSB   10
`define CMD_IMM_LSB   16
`define BYTE_RST      8'h00
`define FLAGS_RST     5'h00
`define LAST_PAGE     4'hF
`define PROG_AW       12
`define DMEM_AW       6
`define SECT_W        2
`define BCD_DIGIT_MAX 4'h9
`define BCD_LOW_ADJ   8'h06
`define BCD_HIGH_ADJ  8'h60
`endif

// ### common/ext_alu_pkg.sv
// types shared by the alu unit: operation codes and sequencer states
// assumes nothing of its surroundings
package ext_alu_pkg;
  typedef enum logic [4:0] {
    OP_TBL_PAGED      = 5'h00,
    OP_TBL_FINAL      = 5'h01,
    OP_TBL_INC_PAGED  = 5'h02,
    OP_TBL_INC_FINAL  = 5'h03,
    OP_XOR_MEM        = 5'h04,
    OP_XOR_IMM        = 5'h05,
    OP_ADD_CARRY      = 5'h06,
    OP_ADD            = 5'h07,
    OP_AND            = 5'h08,
    OP_OR             = 5'h09,
    OP_CLEAR          = 5'h0A,
    OP_CLEAR_BIT      = 5'h0B,
    OP_COMPL          = 5'h0C,
    OP_BCD_ADJ        = 5'h0D,
    OP_DEC            = 5'h0E,
    OP_INC            = 5'h0F,
    OP_MOVE_TO_ACC    = 5'h10,
    OP_MOVE_TO_MEM    = 5'h11,
    OP_ROT_LEFT       = 5'h12,
    OP_ROT_LEFT_CARRY = 5'h13
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_TREQ = 2'b10,
    ST_TCAP = 2'b11
  } state_t;
endpackage

// ### hw/data_mem.sv
// data memory of the alu unit: flip-flop array, one write port and
// two combinational read ports; contents are not reset
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_regs.svh"

module data_mem (
  input  wire logic                clk,
  input  wire logic                wrEn,
  input  wire logic [`DMEM_AW-1:0] wrAddr,
  input  wire logic [7:0]          wrData,
  input  wire logic [`DMEM_AW-1:0] rdAddrA,
  output logic      [7:0]          rdDataA,
  input  wire logic [`DMEM_AW-1:0] rdAddrB,
  output logic      [7:0]          rdDataB
);
  logic [7:0] cell_r [2**`DMEM_AW];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      cell_r[wrAddr] <= wrData;
    end
  end

  assign rdDataA = cell_r[rdAddrA];
  assign rdDataB = cell_r[rdAddrB];
endmodule
`default_nettype wire

// ### hw/alu_core.sv
// combinational result, flag and destination logic of the alu unit
// assumes operands are stable for the whole execute cycle
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_regs.svh"

module alu_core (
  input  wire ext_alu_pkg::op_t op,
  input  wire logic             dstAcc,
  input  wire logic [2:0]       bitSel,
  input  wire logic [7:0]       accIn,
  input  wire logic [7:0]       memIn,
  input  wire logic [7:0]       immIn,
  input  wire logic [4:0]       flagsIn,
  output logic      [7:0]       result,
  output logic      [4:0]       flagsOut,
  output logic                  accWe,
  output logic                  memWe
);
  import ext_alu_pkg::*;

  logic [8:0] sum;
  logic [4:0] halfSum;
  logic [8:0] bcdSum;
  logic [7:0] bcdAdd;
  logic       cin;
  logic       lowFix;
  logic       highFix;
  logic       zUpd;

  always_comb begin
    cin     = (op == OP_ADD_CARRY) && flagsIn[`FLG_CARRY];
    sum     = {1'b0, accIn} + {1'b0, memIn} + {8'h00, cin};
    halfSum = {1'b0, accIn[3:0]} + {1'b0, memIn[3:0]} + {4'h0, cin};
    lowFix  = (accIn[3:0] > `BCD_DIGIT_MAX) || flagsIn[`FLG_HALF];
    highFix = (accIn[7:4] > `BCD_DIGIT_MAX) || flagsIn[`FLG_CARRY];
    bcdAdd  = (lowFix ? `BCD_LOW_ADJ : `BYTE_RST)
            | (highFix ? `BCD_HIGH_ADJ : `BYTE_RST);
    bcdSum  = {1'b0, accIn} + {1'b0, bcdAdd};
    result   = memIn;
    flagsOut = flagsIn;
    accWe    = 1'b0;
    memWe    = 1'b0;
    zUpd     = 1'b0;
    case (op)
      OP_XOR_MEM: begin
        result = accIn ^ memIn;
        zUpd   = 1'b1;
      end
      OP_XOR_IMM: begin
        result = accIn ^ immIn;
        zUpd   = 1'b1;
      end
      OP_ADD_CARRY, OP_ADD: begin
        result = sum[7:0];
        zUpd   = 1'b1;
        flagsOut[`FLG_CARRY]  = sum[8];
        flagsOut[`FLG_HALF]   = halfSum[4];
        flagsOut[`FLG_EXCESS] = (accIn[7] == memIn[7]) && (sum[7] != accIn[7]);
        flagsOut[`FLG_SIGNED] = flagsOut[`FLG_EXCESS] ^ sum[7];
      end
      OP_AND: begin
        result = accIn & memIn;
        zUpd   = 1'b1;
      end
      OP_OR: begin
        result = accIn | memIn;
        zUpd   = 1'b1;
      end
      OP_CLEAR:     result = `BYTE_RST;
      OP_CLEAR_BIT: result = memIn & ~(8'h01 << bitSel);
      OP_COMPL: begin
        result = ~memIn;
        zUpd   = 1'b1;
      end
      OP_BCD_ADJ: begin
        result = bcdSum[7:0];
        flagsOut[`FLG_CARRY] = bcdSum[8] || highFix;
      end
      OP_DEC: begin
        result = memIn - 8'h01;
        zUpd   = 1'b1;
      end
      OP_INC: begin
        result = memIn + 8'h01;
        zUpd   = 1'b1;
      end
      OP_MOVE_TO_ACC: result = memIn;
      OP_MOVE_TO_MEM: result = accIn;
      OP_ROT_LEFT:    result = {memIn[6:0], memIn[7]};
      OP_ROT_LEFT_CARRY: begin
        result = {memIn[6:0], flagsIn[`FLG_CARRY]};
        flagsOut[`FLG_CARRY] = memIn[7];
      end
      default: result = memIn;
    endcase
    if (zUpd) begin
      flagsOut[`FLG_ZERO] = (result == `BYTE_RST);
    end
    // destination: fixed for some operations, none for table reads, chosen by dstAcc for the rest
    case (op)
      OP_XOR_IMM, OP_MOVE_TO_ACC: accWe = 1'b1;
      OP_CLEAR, OP_CLEAR_BIT, OP_BCD_ADJ, OP_MOVE_TO_MEM: memWe = 1'b1;
      OP_XOR_MEM, OP_ADD_CARRY, OP_ADD, OP_AND, OP_OR, OP_COMPL, OP_DEC,
      OP_INC, OP_ROT_LEFT, OP_ROT_LEFT_CARRY: begin
        accWe = dstAcc;
        memWe = !dstAcc;
      end
      default: accWe = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### hw/ext_alu_table_read_exec.sv
// table read and extended alu execution unit with an apb register file
// assumes a program rom that answers one cycle after progRd and one
// apb master; the data memory lives inside this unit
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_regs.svh"

// How it works
// - paged table read: low byte to memory, high byte to latch, no flags.
// - final-page table read addresses last page by low pointer only.
// - pre-increment paged read bumps low pointer, then reads paged word.
// - pre-increment final-page read bumps low pointer, then reads last page.
// - xor of accumulator with memory or immediate, only zero flag changes.
// - extended operations address any memory section directly.
// - add with carry sums accumulator, memory and carry; five flags.
// - add sums accumulator and memory without carry; five flags.
// - and of accumulator and memory, only zero flag changes.
// - or of accumulator and memory, only zero flag changes.
// - byte clear writes zero to memory, flags untouched.
// - bit clear zeroes one selected bit only, flags untouched.
// - complement inverts memory byte to memory or accumulator; zero flag.
// - decimal adjust adds six per nibble over nine or carried; to memory.
// - decimal adjust changes only carry, set when carry was set or the high nibble was over nine.
// - decrement memory to memory or accumulator, only zero flag changes.
// - increment memory to memory or accumulator, only zero flag changes.
// - moves copy memory to accumulator or back, flags untouched.
// - rotate left puts bit 7 into bit 0, flags untouched.
// - rotate left through carry moves bit 7 into carry and carry into bit 0; only carry.
module ext_alu_table_read_exec (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [`PROG_AW-1:0] progAddr,
  output logic                     progRd,
  input  wire logic [15:0]         progData
);
  import ext_alu_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  state_t              state_r, state_nxt;
  logic                wasIdle_r, wasIdle_nxt;
  logic [7:0]          acc_r, acc_nxt;
  logic [4:0]          flags_r, flags_nxt;
  logic [7:0]          tpl_r, tpl_nxt;
  logic [7:0]          tph_r, tph_nxt;
  logic [7:0]          table_read_high_latch_r, table_read_high_latch_nxt;
  logic [`SECT_W-1:0]  sect_r, sect_nxt;
  logic [`DMEM_AW-1:0] memAddr_r, memAddr_nxt;
  op_t                 op_r, op_nxt;
  logic                dst_r, dst_nxt;
  logic [2:0]          bit_r, bit_nxt;
  logic [`DMEM_AW-1:0] adr_r, adr_nxt;
  logic [7:0]          imm_r, imm_nxt;
  logic [`PROG_AW-1:0] progAddr_r, progAddr_nxt;
  logic                progRd_r, progRd_nxt;
  logic [31:0]         prdata_r, prdata_nxt;

  logic                apbAcc;
  logic                apbWr;
  logic                startCmd;
  op_t                 cmdOp;
  logic                cmdTable;
  logic                cmdPreinc;
  logic                cmdFinal;
  logic [7:0]          nextTpl;
  logic [`DMEM_AW-1:0] operandAddr;
  logic [7:0]          memRd;
  logic [7:0]          winRd;
  logic                memWe;
  logic [`DMEM_AW-1:0] memWAddr;
  logic [7:0]          memWData;
  logic [7:0]          aluRes;
  logic [4:0]          aluFlags;
  logic                aluAccWe;
  logic                aluMemWe;

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == `ACC_OFS) || (a == `STATUS_OFS) || (a == `TPL_OFS)
          || (a == `TPH_OFS) || (a == `TABLE_READ_HIGH_LATCH_OFS) || (a == `SECT_OFS)
          || (a == `CMD_OFS) || (a == `MADDR_OFS) || (a == `MDATA_OFS);
  endfunction

  function automatic logic isFinalPage(input op_t o);
    isFinalPage = (o == OP_TBL_FINAL) || (o == OP_TBL_INC_FINAL);
  endfunction

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  // one idle cycle before pready so the registered read data has
  // already seen the results of the last operation
  assign pready   = (state_r == ST_IDLE) && wasIdle_r;
  assign apbAcc   = psel && penable && pready;
  assign apbWr    = apbAcc && pwrite;
  assign pslverr  = apbAcc && !regHit(paddr);
  assign prdata   = prdata_r;
  assign progAddr = progAddr_r;
  assign progRd   = progRd_r;

  assign startCmd  = apbWr && (paddr == `CMD_OFS);
  assign cmdOp     = op_t'(pwdata[`CMD_OP_LSB +: 5]);
  assign cmdTable  = (cmdOp == OP_TBL_PAGED) || (cmdOp == OP_TBL_FINAL)
                  || (cmdOp == OP_TBL_INC_PAGED)
                  || (cmdOp == OP_TBL_INC_FINAL);
  assign cmdPreinc = (cmdOp == OP_TBL_INC_PAGED)
                  || (cmdOp == OP_TBL_INC_FINAL);
  assign cmdFinal  = isFinalPage(cmdOp);
  assign nextTpl   = cmdPreinc ? tpl_r + 8'h01 : tpl_r;

  // extended operations carry the full address, the others reach
  // only the section selected by the section register
  assign operandAddr = (op_r >= OP_ADD_CARRY) ? adr_r
                     : {sect_r, adr_r[`DMEM_AW-`SECT_W-1:0]};

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  alu_core u_alu (
    .op       (op_r),
    .dstAcc   (dst_r),
    .bitSel   (bit_r),
    .accIn    (acc_r),
    .memIn    (memRd),
    .immIn    (imm_r),
    .flagsIn  (flags_r),
    .result   (aluRes),
    .flagsOut (aluFlags),
    .accWe    (aluAccWe),
    .memWe    (aluMemWe)
  );

  data_mem u_mem (
    .clk     (clk),
    .wrEn    (memWe),
    .wrAddr  (memWAddr),
    .wrData  (memWData),
    .rdAddrA (operandAddr),
    .rdDataA (memRd),
    .rdAddrB (memAddr_r),
    .rdDataB (winRd)
  );

  always_comb begin
    memWe    = 1'b0;
    memWAddr = operandAddr;
    memWData = aluRes;
    if (state_r == ST_EXEC) begin
      memWe = aluMemWe;
    end else if (state_r == ST_TCAP) begin
      memWe    = 1'b1;
      memWData = progData[7:0];
    end else if (apbWr && (paddr == `MDATA_OFS)) begin
      memWe    = 1'b1;
      memWAddr = memAddr_r;
      memWData = pwdata[7:0];
    end
  end

  // ------------------------------------------------------------------
  // sequencer and registers
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    wasIdle_nxt  = (state_r == ST_IDLE);
    acc_nxt      = acc_r;
    flags_nxt    = flags_r;
    tpl_nxt      = tpl_r;
    tph_nxt      = tph_r;
    table_read_high_latch_nxt     = table_read_high_latch_r;
    sect_nxt     = sect_r;
    memAddr_nxt  = memAddr_r;
    op_nxt       = op_r;
    dst_nxt      = dst_r;
    bit_nxt      = bit_r;
    adr_nxt      = adr_r;
    imm_nxt      = imm_r;
    progAddr_nxt = progAddr_r;
    progRd_nxt   = 1'b0;
    if (apbWr) begin
      case (paddr)
        `ACC_OFS:    acc_nxt     = pwdata[7:0];
        `STATUS_OFS: flags_nxt   = pwdata[4:0];
        `TPL_OFS:    tpl_nxt     = pwdata[7:0];
        `TPH_OFS:    tph_nxt     = pwdata[7:0];
        `SECT_OFS:   sect_nxt    = pwdata[`SECT_W-1:0];
        `MADDR_OFS:  memAddr_nxt = pwdata[`DMEM_AW-1:0];
        default:     acc_nxt     = acc_r;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        if (startCmd) begin
          op_nxt  = cmdOp;
          dst_nxt = pwdata[`CMD_DST_BIT];
          bit_nxt = pwdata[`CMD_BIT_LSB +: 3];
          adr_nxt = pwdata[`CMD_ADR_LSB +: `DMEM_AW];
          imm_nxt = pwdata[`CMD_IMM_LSB +: 8];
          if (cmdTable) begin
            tpl_nxt    = nextTpl;
            progRd_nxt = 1'b1;
            state_nxt  = ST_TREQ;
            if (cmdFinal) begin
              progAddr_nxt = {`LAST_PAGE, nextTpl};
            end else begin
              progAddr_nxt = {tph_r[`PROG_AW-9:0], nextTpl};
            end
          end else begin
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (aluAccWe) begin
          acc_nxt = aluRes;
        end
        flags_nxt = aluFlags;
        state_nxt = ST_IDLE;
      end
      ST_TREQ: state_nxt = ST_TCAP;
      ST_TCAP: begin
        table_read_high_latch_nxt  = progData[15:8];
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      `ACC_OFS:    prdata_nxt[7:0] = acc_r;
      `STATUS_OFS: begin
        prdata_nxt[4:0]        = flags_r;
        prdata_nxt[`STAT_BUSY] = (state_r != ST_IDLE);
      end
      `TPL_OFS:    prdata_nxt[7:0] = tpl_r;
      `TPH_OFS:    prdata_nxt[7:0] = tph_r;
      `TABLE_READ_HIGH_LATCH_OFS:   prdata_nxt[7:0] = table_read_high_latch_r;
      `SECT_OFS:   prdata_nxt[`SECT_W-1:0] = sect_r;
      `MADDR_OFS:  prdata_nxt[`DMEM_AW-1:0] = memAddr_r;
      `MDATA_OFS:  prdata_nxt[7:0] = winRd;
      default:     prdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      wasIdle_r  <= 1'b0;
      acc_r      <= `BYTE_RST;
      flags_r    <= `FLAGS_RST;
      tpl_r      <= `BYTE_RST;
      tph_r      <= `BYTE_RST;
      table_read_high_latch_r     <= `BYTE_RST;
      sect_r     <= '0;
      memAddr_r  <= '0;
      op_r       <= OP_MOVE_TO_ACC;
      dst_r      <= 1'b0;
      bit_r      <= 3'h0;
      adr_r      <= '0;
      imm_r      <= `BYTE_RST;
      progAddr_r <= '0;
      progRd_r   <= 1'b0;
      prdata_r   <= 32'h0000_0000;
    end else begin
      state_r    <= state_nxt;
      wasIdle_r  <= wasIdle_nxt;
      acc_r      <= acc_nxt;
      flags_r    <= flags_nxt;
      tpl_r      <= tpl_nxt;
      tph_r      <= tph_nxt;
      table_read_high_latch_r     <= table_read_high_latch_nxt;
      sect_r     <= sect_nxt;
      memAddr_r  <= memAddr_nxt;
      op_r       <= op_nxt;
      dst_r      <= dst_nxt;
      bit_r      <= bit_nxt;
      adr_r      <= adr_nxt;
      imm_r      <= imm_nxt;
      progAddr_r <= progAddr_nxt;
      progRd_r   <= progRd_nxt;
      prdata_r   <= prdata_nxt;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic [7:0] progHigh;
  logic [3:0] flagsNoZero;
  logic [8:0] plainSum;
  logic       plainCarry;
  logic [7:0] rotRef;
  logic       exec;
  assign progHigh    = progData[15:8];
  assign flagsNoZero = {flags_r[4:3], flags_r[1:0]};
  assign plainSum    = {1'b0, acc_r} + {1'b0, memRd};
  assign plainCarry  = plainSum[8];
  assign rotRef      = {memRd[6:0], memRd[7]};
  assign exec        = (state_r == ST_EXEC);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  tblFlagsHold_a: assert property (
    (state_r == ST_TREQ) |=> (state_r == ST_TCAP) ##1
    (flags_r == $past(flags_r, 2) && table_read_high_latch_r == $past(progHigh)))
    else $error("table read changed flags or missed the high byte");

  pagedAddr_a: assert property (
    (state_r == ST_TREQ && !isFinalPage(op_r)) |->
    (progAddr == {tph_r[`PROG_AW-9:0], tpl_r} && progRd))
    else $error("paged table address is not high and low pointer");

  finalAddr_a: assert property (
    (state_r == ST_TREQ && isFinalPage(op_r)) |->
    (progAddr == {`LAST_PAGE, tpl_r} && progRd))
    else $error("final page table address is wrong");

  preincStep_a: assert property (
    (startCmd && cmdPreinc) |=>
    (tpl_r == 8'($past(tpl_r) + 8'h01)) ##1 (progAddr[7:0] == tpl_r))
    else $error("low pointer not incremented before the read");

  noPreinc_a: assert property (
    (startCmd && cmdTable && !cmdPreinc) |=> $stable(tpl_r))
    else $error("low pointer moved on a plain table read");

  xorZeroOnly_a: assert property (
    (exec && (op_r == OP_XOR_MEM || op_r == OP_XOR_IMM)) |=>
    (flagsNoZero == $past(flagsNoZero)))
    else $error("xor changed a flag other than zero");

  addCarry_a: assert property (
    (exec && op_r == OP_ADD) |=> (flags_r[`FLG_CARRY] == $past(plainCarry)))
    else $error("add carry does not match the nine-bit sum");

  zeroFlag_a: assert property (
    (exec && op_r inside {OP_XOR_MEM, OP_XOR_IMM, OP_ADD, OP_ADD_CARRY,
                          OP_AND, OP_OR, OP_COMPL, OP_DEC, OP_INC}) |=>
    (flags_r[`FLG_ZERO] == ($past(aluRes) == `BYTE_RST)))
    else $error("zero flag disagrees with the result");

  clearByte_a: assert property (
    (exec && op_r == OP_CLEAR) |-> (memWe && memWData == `BYTE_RST)
    ##1 (flags_r == $past(flags_r)))
    else $error("byte clear did not write zero or touched flags");

  bcdCarry_a: assert property (
    (exec && op_r == OP_BCD_ADJ &&
     (flags_r[`FLG_CARRY] || acc_r[7:4] > `BCD_DIGIT_MAX)) |=>
    (flags_r[`FLG_CARRY] && $stable(acc_r)))
    else $error("decimal adjust lost the decimal carry");

  moveNoFlags_a: assert property (
    (exec && op_r == OP_MOVE_TO_ACC) |=>
    (acc_r == $past(memRd) && flags_r == $past(flags_r)))
    else $error("move to accumulator wrong or flags changed");

  rotLeft_a: assert property (
    (exec && op_r == OP_ROT_LEFT && dst_r) |=>
    (acc_r == $past(rotRef) && flags_r == $past(flags_r)))
    else $error("rotate left result or flags wrong");

  tblFinalSeen_c: cover property (
    (startCmd && cmdOp == OP_TBL_INC_FINAL) ##3 (state_r == ST_IDLE));
  addCarrySeen_c: cover property (
    exec && op_r == OP_ADD_CARRY && flags_r[`FLG_CARRY]);
  bcdCarrySeen_c: cover property (
    exec && op_r == OP_BCD_ADJ ##1 flags_r[`FLG_CARRY]);
  xorMemSeen_c: cover property (exec && op_r == OP_XOR_MEM && !dst_r);
endmodule
`default_nettype wire

// ### verification/prog_rom_model.sv
// program rom stand-in for the table read unit
// assumes progData is sampled one cycle after progRd
`timescale 1ns/1ps
`default_nettype none

module prog_rom_model (
  input  wire logic        clk,
  input  wire logic [11:0] progAddr,
  input  wire logic        progRd,
  output logic      [15:0] progData
);
  logic [15:0] word_r = 16'h5A5A;

  // low byte shows page and pointer top, high byte the inverted pointer;
  // outside the answer cycle the word flips, so a late sample shows up
  always @(posedge clk) begin
    if (progRd) begin
      word_r <= {~progAddr[7:0], progAddr[11:4]};
    end else begin
      word_r <= ~word_r;
    end
  end
  assign progData = word_r;
endmodule

`default_nettype wire

// ### verification/tb_ext_alu_table_read_exec.sv
// self-checking bench for the table read and extended alu unit
// assumes the rom model beside it and the apb map of the register header
`timescale 1ns/1ps
`default_nettype none
`include "ext_alu_regs.svh"

module tb_ext_alu_table_read_exec;
  import ext_alu_pkg::*;
  typedef struct packed {
    op_t op; logic dst; logic [7:0] acc; logic [7:0] mem; logic [4:0] fin;
    logic [7:0] eAcc; logic [7:0] eMem; logic [4:0] eFlg;
  } row_t;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] progAddr;
  logic        progRd;
  logic [15:0] progData;
  logic [31:0] q;
  logic        e;
  int          err_total = 0;
  int          n_checks = 0;
  row_t rows [21] = '{
    '{OP_XOR_MEM,0,'h5A,'h5A,'h00,'h5A,'h00,'h04},
    '{OP_XOR_IMM,1,'hF0,'h33,'h04,'hFF,'h33,'h00},
    '{OP_ADD_CARRY,1,'h7F,'h00,'h01,'h80,'h00,'h0A},
    '{OP_ADD,0,'hFF,'h01,'h01,'hFF,'h00,'h07},
    '{OP_AND,1,'hF0,'h0F,'h1B,'h00,'h0F,'h1F},
    '{OP_OR,0,'h30,'h03,'h05,'h30,'h33,'h01},
    '{OP_CLEAR,0,'h12,'h77,'h00,'h12,'h00,'h00},
    '{OP_CLEAR_BIT,0,'h12,'hFF,'h00,'h12,'hF7,'h00},
    '{OP_COMPL,1,'h00,'hFF,'h00,'h00,'hFF,'h04},
    '{OP_BCD_ADJ,0,'hA5,'h11,'h02,'hA5,'h0B,'h03},
    '{OP_BCD_ADJ,0,'h45,'h11,'h10,'h45,'h45,'h10},
    '{OP_DEC,1,'h12,'h01,'h00,'h00,'h01,'h04},
    '{OP_INC,0,'h12,'hFF,'h01,'h12,'h00,'h05},
    '{OP_MOVE_TO_ACC,1,'h00,'h80,'h04,'h80,'h80,'h04},
    '{OP_MOVE_TO_MEM,0,'h3C,'h55,'h00,'h3C,'h3C,'h00},
    '{OP_ROT_LEFT,0,'h12,'h81,'h00,'h12,'h03,'h00},
    '{OP_ROT_LEFT_CARRY,1,'h12,'h80,'h00,'h00,'h80,'h01},
    '{OP_XOR_MEM,1,'h0F,'hF0,'h00,'hFF,'hF0,'h00},
    '{OP_COMPL,0,'h12,'h0F,'h04,'h12,'hF0,'h00},
    '{OP_ROT_LEFT,1,'h12,'h40,'h1F,'h80,'h40,'h1F},
    '{OP_ROT_LEFT_CARRY,0,'h12,'h01,'h01,'h12,'h03,'h00}};

  ext_alu_table_read_exec i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progAddr(progAddr), .progRd(progRd), .progData(progData));
  prog_rom_model i_rom (.clk(clk), .progAddr(progAddr), .progRd(progRd),
    .progData(progData));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pready is sampled at the rising edge that ends the access phase;
  // read data and the error flag are taken at that same edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic tbl(input op_t op, input logic [7:0] tpl,
                     input logic [15:0] eWord, input logic [7:0] eTpl);
    xfer(1'b1, `TPL_OFS, {24'h00_0000, tpl});
    xfer(1'b1, `CMD_OFS, {16'h0000, 6'h0A, 5'h00, op});
    rd(`MDATA_OFS, {24'h00_0000, eWord[7:0]});
    rd(`TABLE_READ_HIGH_LATCH_OFS, {24'h00_0000, eWord[15:8]});
    rd(`TPL_OFS, {24'h00_0000, eTpl});
    rd(`STATUS_OFS, 32'h0000_0015);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`STATUS_OFS, 32'h0000_0000);
    xfer(1'b1, `MADDR_OFS, 32'h0000_002A);
    foreach (rows[i]) begin
      xfer(1'b1, `SECT_OFS, (rows[i].op < OP_ADD_CARRY) ? 32'h2 : 32'h0);
      xfer(1'b1, `ACC_OFS, {24'h00_0000, rows[i].acc});
      xfer(1'b1, `STATUS_OFS, {27'h000_0000, rows[i].fin});
      xfer(1'b1, `MDATA_OFS, {24'h00_0000, rows[i].mem});
      xfer(1'b1, `CMD_OFS, {8'h00, 8'h0F, 6'h2A, 1'b0, 3'd3, rows[i].dst,
                            rows[i].op});
      rd(`ACC_OFS, {24'h00_0000, rows[i].eAcc});
      rd(`MDATA_OFS, {24'h00_0000, rows[i].eMem});
      rd(`STATUS_OFS, {27'h000_0000, rows[i].eFlg});
    end
    // table reads: pointer wrap on pre-increment, last page addressing
    xfer(1'b1, `SECT_OFS, 32'h0000_0002);
    xfer(1'b1, `STATUS_OFS, 32'h0000_0015);
    xfer(1'b1, `TPH_OFS, 32'h0000_0003);
    tbl(OP_TBL_PAGED, 8'hFF, 16'h003F, 8'hFF);
    tbl(OP_TBL_FINAL, 8'hFF, 16'h00FF, 8'hFF);
    tbl(OP_TBL_INC_PAGED, 8'hFF, 16'hFF30, 8'h00);
    tbl(OP_TBL_INC_FINAL, 8'h7F, 16'h7FF8, 8'h80);
    // latch is read-only and an unmapped place answers with an error
    xfer(1'b1, `TABLE_READ_HIGH_LATCH_OFS, 32'h0000_00FF);
    chk({31'h0, e}, 32'h0000_0000);
    rd(`TABLE_READ_HIGH_LATCH_OFS, 32'h0000_007F);
    xfer(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ACC_OFS, 32'h0000_0000);
    finish_test();
  end
endmodule

`default_nettype wire
